// file: bench/sdc_host_model.sv
// Host-side model: master clock and a first-order modulator bit stream.
// Assumes hclk at 250 MHz; the master clock is hclk divided by eight.
`timescale 1ns/10ps

module sdc_host_model
	import sdc_pkg::*;
(
	// Clock
	input wire logic hclk,
	// Analog side
	input wire sdc_in_sel_t input_select,
	input wire logic [7:0] ain_level,
	// Converter pins
	output logic master_clock_in,
	output logic mod_bit_in
);
	logic [2:0] div_q = 3'h0;
	logic [8:0] acc_q = 9'h000;
	logic [7:0] lvl;

	// Ground and reference sit at a quarter and three quarters of full density.
	assign lvl = (input_select == IN_GND) ? 8'h40 : (input_select == IN_REF) ? 8'hC0 : ain_level;
	assign master_clock_in = div_q[2];
	assign mod_bit_in = acc_q[8];

	always @(posedge hclk) begin
		div_q <= div_q + 3'h1;
		if (div_q == 3'h3) begin
			acc_q <= {1'b0, acc_q[7:0]} + {1'b0, lvl};
		end
	end
endmodule

// file: bench/testbench.sv
// Self-checking bench for the calibration control block.
// Assumes the package, the design and the host model are compiled first.
`timescale 1ns/10ps

module testbench;
	import sdc_pkg::*;
	localparam int TK = 8;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic sc1 = 1'b0;
	logic sc2 = 1'b0;
	logic pol = 1'b0;
	logic cal = 1'b0;
	logic [7:0] ain = 8'h80;
	logic hreadyout, hresp, mclk, mbit, ready_n;
	logic [31:0] hrdata, rd, s1;
	sdc_in_sel_t sel;
	sdc_result_t res;
	int err_count = 0;
	int num_checks = 0;
	int cyc = 0;

	sdc_cal_ctrl #(.SELF_CAL_CYC(200), .SYS_OFF_CYC(100), .SYS_GAIN_CYC(100), .ONE_OFF_CYC(200)) sdc_cal_ctrl_i (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .master_clock_in(mclk),
		.mod_bit_in(mbit), .cal_strobe_in(cal), .cal_type_select_1(sc1),
		.cal_type_select_2(sc2), .polarity_select(pol), .result_ready_n(ready_n),
		.input_select(sel), .result_out(res));

	sdc_host_model sdc_host_model_i (.hclk(hclk), .input_select(sel), .ain_level(ain),
		.master_clock_in(mclk), .mod_bit_in(mbit));

	always #2 hclk = ~hclk;

	always @(posedge hclk) begin
		cyc++;
		if (cyc == 60000) begin
			err_count++;
			conclude();
		end
	end

	// ----
	// Tasks
	// ----
	task conclude();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [2:0] s);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		hsize <= s;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	// Strobe high for hi master ticks, then watch the step for its word and mux choices.
	task automatic run_cal(input logic [1:0] code, input int hi, input int n, input logic want,
		input logic [19:0] w, input sdc_in_sel_t sa, input sdc_in_sel_t sb);
		logic got = 1'b0;
		logic early = 1'b0;
		int at = 0;
		logic [31:0] a = 32'h0;
		logic [31:0] b = 32'h0;
		@(posedge hclk);
		sc1 <= code[1];
		sc2 <= code[0];
		@(posedge hclk);
		cal <= 1'b1;
		repeat (hi * TK) @(posedge hclk);
		cal <= 1'b0;
		for (int c = 0; c < n * TK + 80 && !got; c++) begin
			@(posedge hclk);
			#1;
			if (c == n * 2) a = {30'h0, sel};
			if (c == n * 6) b = {30'h0, sel};
			if (res.valid === 1'b1) begin
				got = 1'b1;
				at = c;
				chk("cal word", {12'h0, res.word}, {12'h0, w});
				chk("ready low", {31'h0, ready_n}, 32'h0);
			end else if (ready_n !== 1'b1) begin
				early = 1'b1;
			end
		end
		chk("word given", {31'h0, got}, {31'h0, want});
		chk("ready held", {31'h0, early}, 32'h0);
		chk("sel first", a, {30'h0, sa});
		chk("sel second", b, {30'h0, sb});
		if (want) chk("step len", {31'h0, at >= (n - 1) * TK && at <= (n + 4) * TK}, 32'h1);
		$display("cal step %b done", code);
	endtask

	// Waits up to one word period plus 200 cycles for a free-running word, then reads it back over the bus.
	task automatic wait_word();
		logic [31:0] w = 32'h0;
		logic got = 1'b0;
		for (int c = 0; c < WORD_DIV * TK + 200 && !got; c++) begin
			@(posedge hclk);
			#1;
			if (res.valid === 1'b1) begin
				got = 1'b1;
				w = {12'h0, res.word};
				chk("word ready", {31'h0, ready_n}, 32'h0);
			end
		end
		chk("free word", {31'h0, got}, 32'h1);
		bus(1'b0, REG_RESULT, 32'h0, HSIZE_WORD);
		chk("word read", rd, w);
		$display("word test done");
	endtask

	initial begin
		repeat (4) @(posedge hclk);
		chk("reset result", {11'h0, res}, 32'h0);
		chk("reset sel", {30'h0, sel}, {30'h0, IN_AIN});
		@(posedge hclk);
		hresetn <= 1'b1;
		bus(1'b1, REG_CTRL, 32'h1, HSIZE_WORD);
		bus(1'b0, REG_CTRL, 32'h0, HSIZE_WORD);
		chk("ctrl set", rd, 32'h1);
		bus(1'b1, REG_CTRL, 32'h0, 3'h0);
		bus(1'b0, REG_CTRL, 32'h0, HSIZE_WORD);
		chk("ctrl byte", rd, 32'h1);
		bus(1'b1, REG_CTRL, 32'h0, HSIZE_WORD);
		bus(1'b0, 8'h14, 32'h0, HSIZE_WORD);
		chk("unmapped", rd, 32'h0);
		bus(1'b0, REG_STATUS, 32'h0, HSIZE_WORD);
		chk("status reset", rd, 32'h5);
		chk("hresp", {31'h0, hresp}, 32'h0);
		$display("register test done");
		run_cal(2'b01, 6, 100, 1'b0, CODE_ZERO, IN_AIN, IN_AIN);
		run_cal(2'b11, 2, 100, 1'b0, CODE_ZERO, IN_AIN, IN_AIN);
		run_cal(2'b11, 6, 100, 1'b1, CODE_ZERO, IN_AIN, IN_AIN);
		bus(1'b0, REG_RESULT, 32'h0, HSIZE_WORD);
		#1;
		chk("result read", rd, 32'h0);
		chk("ready after read", {31'h0, ready_n}, 32'h1);
		bus(1'b0, REG_STATUS, 32'h0, HSIZE_WORD);
		chk("status offset", rd, 32'hD);
		ain <= 8'hE0;
		run_cal(2'b01, 6, 100, 1'b1, CODE_FULL, IN_AIN, IN_AIN);
		bus(1'b0, REG_STATUS, 32'h0, HSIZE_WORD);
		chk("two step", {31'h0, rd[STAT_TWO_STEP_BIT]}, 32'h1);
		bus(1'b0, REG_SLOPE, 32'h0, HSIZE_WORD);
		s1 = rd;
		ain <= 8'h80;
		run_cal(2'b11, 6, 100, 1'b1, CODE_ZERO, IN_AIN, IN_AIN);
		bus(1'b0, REG_SLOPE, 32'h0, HSIZE_WORD);
		chk("span kept", rd, s1);
		run_cal(2'b10, 6, 200, 1'b1, CODE_ZERO, IN_AIN, IN_REF);
		run_cal(2'b00, 6, 200, 1'b0, CODE_ZERO, IN_GND, IN_REF);
		wait_word();
		pol <= 1'b1;
		repeat (20) @(posedge hclk);
		bus(1'b0, REG_STATUS, 32'h0, HSIZE_WORD);
		chk("bipolar", {29'h0, rd[STAT_BIPOLAR_BIT], rd[STAT_SETTLING_BIT], rd[STAT_BUSY_BIT]}, 32'h6);
		$display("polarity test done");
		conclude();
	end
endmodule

// file: src/sdc_cal_ctrl.sv
// Digital control of a continuously converting sigma-delta converter: decimation, calibration, coding.
// Assumes pins arrive asynchronously to hclk and the master clock is far slower than hclk.
`timescale 1ns/10ps

module sdc_cal_ctrl
	import sdc_pkg::*;
#(
	parameter int SELF_CAL_CYC = 3145655,
	parameter int SYS_OFF_CYC = 1052599,
	parameter int SYS_GAIN_CYC = 1068813,
	parameter int ONE_OFF_CYC = 2117389
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Converter pins
	input wire logic master_clock_in,
	input wire logic mod_bit_in,
	input wire logic cal_strobe_in,
	input wire logic cal_type_select_1,
	input wire logic cal_type_select_2,
	input wire logic polarity_select,
	output logic result_ready_n,
	output sdc_in_sel_t input_select,
	// Serial port side
	output sdc_result_t result_out
);

	sdc_regs_t q, d;
	logic tick, word_end, cal_rise, cal_fall, ahb_take;
	logic [ACC_W-1:0] word_sum;
	logic signed [FILT_W:0] filt_diff, filt_step;
	logic [FILT_W-1:0] mag;
	logic [DIV_NW-1:0] dividend;
	logic div_busy, div_done;
	logic [DIV_NW-1:0] quo;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Turns a quotient into the output code, clamped at both ends.
	function automatic logic [WORD_BITS-1:0] code_of(input logic [DIV_NW-1:0] qv, input logic neg, input logic bip);
		logic big;
		big = qv >= DIV_NW'(CODE_MID);
		if (!bip) begin
			code_of = neg ? CODE_ZERO : ((qv > DIV_NW'(CODE_FULL)) ? CODE_FULL : qv[WORD_BITS-1:0]);
		end else if (neg) begin
			code_of = big ? CODE_ZERO : CODE_MID - qv[WORD_BITS-1:0];
		end else begin
			code_of = big ? CODE_FULL : CODE_MID + qv[WORD_BITS-1:0];
		end
	endfunction

	function automatic logic [31:0] reg_read(input sdc_regs_t r, input logic [ADDR_W-1:0] a);
		reg_read = '0;
		case (a)
			REG_CTRL: reg_read[CTRL_FREEZE_BIT] = r.freeze;
			REG_STATUS: begin
				reg_read[STAT_READY_N_BIT] = r.ready_n;
				reg_read[STAT_BUSY_BIT] = r.state != ST_CONV;
				reg_read[STAT_SETTLING_BIT] = r.settle != '0;
				reg_read[STAT_OFFSET_BIT] = r.offset_done;
				reg_read[STAT_TWO_STEP_BIT] = r.two_step_done;
				reg_read[STAT_BIPOLAR_BIT] = r.pol_s2;
			end
			REG_RESULT: reg_read = 32'(r.result);
			REG_ZERO: reg_read = 32'(r.zero);
			REG_SLOPE: reg_read = 32'(r.span);
			default: reg_read = '0;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Slope application
	// ----------------------------------------------------------------
	// The sign comes from the same filter value that the divider latches, so magnitude and sign agree.
	assign mag = (q.filt < q.zero) ? q.zero - q.filt : q.filt - q.zero;
	// Dividing by span scaled down by 2^20 or 2^19 is the same as shifting the numerator up.
	assign dividend = q.pol_s2 ? DIV_NW'(mag) << BI_SHIFT : DIV_NW'(mag) << UNI_SHIFT;

	sdc_divider u_div (
		.hclk(hclk),
		.hresetn(hresetn),
		.start(q.div_start),
		.dividend(dividend),
		.divisor(q.span),
		.busy(div_busy),
		.done(div_done),
		.quotient(quo)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		d = q;
		d.res_valid = 1'b0;
		d.div_start = 1'b0;
		d.mclk_s1 = master_clock_in;
		d.mclk_s2 = q.mclk_s1;
		d.mclk_s3 = q.mclk_s2;
		d.mod_s1 = mod_bit_in;
		d.mod_s2 = q.mod_s1;
		d.cal_s1 = cal_strobe_in;
		d.cal_s2 = q.cal_s1;
		d.cal_s3 = q.cal_s2;
		d.sc1_s1 = cal_type_select_1;
		d.sc1_s2 = q.sc1_s1;
		d.sc2_s1 = cal_type_select_2;
		d.sc2_s2 = q.sc2_s1;
		d.pol_s1 = polarity_select;
		d.pol_s2 = q.pol_s1;
		d.pol_prev = q.pol_s2;
		tick = q.mclk_s2 && !q.mclk_s3;
		cal_rise = q.cal_s2 && !q.cal_s3;
		cal_fall = !q.cal_s2 && q.cal_s3;
		word_end = tick && (q.word_cnt == WORD_CNT_W'(WORD_DIV - 1));
		ahb_take = hsel && hready && htrans[1];

		// The accumulator runs on every master tick and the filter at every word end, whatever else happens.
		word_sum = q.acc + ACC_W'(q.mod_s2);
		filt_diff = $signed({1'b0, word_sum, {FILT_FRAC{1'b0}}}) - $signed({1'b0, q.filt});
		filt_step = filt_diff >>> FILT_SHIFT;
		if (tick) begin
			d.word_cnt = q.word_cnt + WORD_CNT_W'(1);
			d.acc = word_sum;
			if (word_end) begin
				d.acc = '0;
				// Full modulator density sits above the reference point, leaving overrange room.
				d.filt = FILT_W'($signed({1'b0, q.filt}) + filt_step);
			end
		end

		if (q.cal_s2 && tick && q.hi_cnt != HI_CNT_W'(CAL_MIN_HIGH)) begin
			d.hi_cnt = q.hi_cnt + HI_CNT_W'(1);
		end

		// Reading the result ends its transfer; a step end or a word load in this cycle wins.
		if (ahb_take && !hwrite && haddr[ADDR_W-1:0] == REG_RESULT) begin
			d.ready_n = 1'b1;
		end

		case (q.state)
			ST_ARM: begin
				d.ready_n = 1'b1;
				if (cal_fall) begin
					d.state = ST_CONV;
					if (q.hi_cnt == HI_CNT_W'(CAL_MIN_HIGH)) begin
						case (q.cal_type)
							CAL_SELF: begin
								d.in_sel = IN_GND;
								d.state = ST_CAL_ZERO;
								d.phase = PHASE_W'(SELF_CAL_CYC / 2);
							end
							CAL_SYS_OFF: begin
								d.in_sel = IN_AIN;
								d.state = ST_CAL_ZERO;
								d.phase = PHASE_W'(SYS_OFF_CYC);
							end
							CAL_ONE_OFF: begin
								d.in_sel = IN_AIN;
								d.state = ST_CAL_ZERO;
								d.phase = PHASE_W'(ONE_OFF_CYC / 2);
							end
							CAL_SYS_GAIN: begin
								if (q.offset_done) begin
									d.in_sel = IN_AIN;
									d.state = ST_CAL_FULL;
									d.phase = PHASE_W'(SYS_GAIN_CYC);
								end
							end
							default: d.state = ST_CONV;
						endcase
					end
				end
			end
			ST_CAL_ZERO: begin
				d.ready_n = 1'b1;
				if (tick) begin
					d.phase = q.phase - PHASE_W'(1);
					if (q.phase == PHASE_W'(1)) begin
						d.zero = q.filt;
						if (q.cal_type == CAL_SYS_OFF) begin
							// The span is kept, so a later offset step leaves the gain alone.
							d.offset_done = 1'b1;
							d.result = CODE_ZERO;
							d.ready_n = 1'b0;
							d.res_valid = 1'b1;
							d.settle = SETTLE_W'(SETTLE_WORDS);
							d.state = ST_CONV;
						end else begin
							d.in_sel = IN_REF;
							d.state = ST_CAL_FULL;
							d.phase = (q.cal_type == CAL_SELF) ? PHASE_W'(SELF_CAL_CYC / 2) : PHASE_W'(ONE_OFF_CYC / 2);
						end
					end
				end
			end
			ST_CAL_FULL: begin
				d.ready_n = 1'b1;
				if (tick) begin
					d.phase = q.phase - PHASE_W'(1);
					if (q.phase == PHASE_W'(1)) begin
						d.span = q.filt - q.zero;
						d.in_sel = IN_AIN;
						d.state = ST_CONV;
						if (q.cal_type != CAL_SELF) begin
							d.result = (q.cal_type == CAL_SYS_GAIN) ? CODE_FULL : CODE_ZERO;
							d.two_step_done = q.two_step_done || (q.cal_type == CAL_SYS_GAIN);
							d.ready_n = 1'b0;
							d.res_valid = 1'b1;
							d.settle = SETTLE_W'(SETTLE_WORDS);
						end else begin
							d.settle = '0;
						end
					end
				end
			end
			ST_CONV: begin
				if (q.pol_s2 != q.pol_prev) begin
					d.settle = SETTLE_W'(SETTLE_WORDS);
				end
				if (word_end) begin
					if (q.settle != '0) begin
						d.settle = q.settle - SETTLE_W'(1);
					end else if (!q.freeze && !div_busy && !q.div_pend) begin
						d.div_start = 1'b1;
						d.div_pend = 1'b1;
					end
				end
				if (q.div_start) begin
					d.div_neg = q.filt < q.zero;
				end
				if (div_done && q.div_pend) begin
					d.div_pend = 1'b0;
					d.new_word = code_of(quo, q.div_neg, q.pol_s2);
					d.gap = GAP_W'(READY_GAP);
					d.ready_n = 1'b1;
				end
			end
			default: d.state = ST_CONV;
		endcase

		// AHB-Lite address phase: read data is captured here and stands in the data phase.
		d.aw_valid = ahb_take && hwrite && (hsize == HSIZE_WORD);
		d.aw_addr = haddr[ADDR_W-1:0];
		if (ahb_take && !hwrite) begin
			d.hrdata = reg_read(q, haddr[ADDR_W-1:0]);
		end
		if (q.aw_valid && q.aw_addr == REG_CTRL) begin
			d.freeze = hwdata[CTRL_FREEZE_BIT];
		end

		// Ready stays high for the load gap; the load itself wins over a read in the same cycle.
		if (q.state == ST_CONV && q.gap != '0 && tick) begin
			d.gap = q.gap - GAP_W'(1);
			d.ready_n = 1'b1;
			if (q.gap == GAP_W'(1)) begin
				d.result = q.new_word;
				d.ready_n = 1'b0;
				d.res_valid = 1'b1;
			end
		end

		// A strobe rise resets calibration and latches the type selects.
		if (cal_rise) begin
			d.cal_type = sdc_cal_type_t'({q.sc1_s2, q.sc2_s2});
			d.state = ST_ARM;
			d.hi_cnt = '0;
			d.ready_n = 1'b1;
			d.res_valid = 1'b0;
			d.gap = '0;
			// A division cut short here must not block every later word.
			d.div_pend = 1'b0;
			d.in_sel = IN_AIN;
			d.settle = SETTLE_W'(SETTLE_WORDS);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= '0;
			q.ready_n <= 1'b1;
			q.settle <= SETTLE_W'(SETTLE_WORDS);
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = q.hrdata;
	assign result_ready_n = q.ready_n;
	assign input_select = q.in_sel;
	assign result_out.valid = q.res_valid;
	assign result_out.word = q.result;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	property p_cal_ready_high;
		(q.state == ST_CAL_ZERO || q.state == ST_CAL_FULL) |-> (result_ready_n && !result_out.valid);
	endproperty
	a_cal_ready_high: assert property (p_cal_ready_high) else $error("ready or valid active during calibration");

	property p_self_start;
		(q.state == ST_ARM && cal_fall && q.hi_cnt == HI_CNT_W'(CAL_MIN_HIGH) && q.cal_type == CAL_SELF)
			|=> (q.state == ST_CAL_ZERO && input_select == IN_GND);
	endproperty
	a_self_start: assert property (p_self_start) else $error("self calibration did not start on ground");

	property p_short_strobe;
		(q.state == ST_ARM && cal_fall && q.hi_cnt != HI_CNT_W'(CAL_MIN_HIGH) && !cal_rise) |=> q.state == ST_CONV;
	endproperty
	a_short_strobe: assert property (p_short_strobe) else $error("short strobe started a calibration");

	property p_sys_zero;
		(q.state == ST_CAL_ZERO && tick && q.phase == PHASE_W'(1) && q.cal_type == CAL_SYS_OFF && !cal_rise)
			|=> (!result_ready_n && result_out.word == CODE_ZERO && result_out.valid);
	endproperty
	a_sys_zero: assert property (p_sys_zero) else $error("offset step did not report zero code");

	property p_sys_full;
		(q.state == ST_CAL_FULL && tick && q.phase == PHASE_W'(1) && q.cal_type == CAL_SYS_GAIN && !cal_rise)
			|=> (!result_ready_n && result_out.word == CODE_FULL && q.two_step_done);
	endproperty
	a_sys_full: assert property (p_sys_full) else $error("gain step did not report full code");

	property p_offset_keeps_span;
		(q.state == ST_CAL_ZERO && q.cal_type == CAL_SYS_OFF) |=> q.span == $past(q.span);
	endproperty
	a_offset_keeps_span: assert property (p_offset_keeps_span) else $error("offset step changed the span");

	property p_settle_blocks;
		(q.settle != '0 && q.state == ST_CONV) |=> !q.div_start;
	endproperty
	a_settle_blocks: assert property (p_settle_blocks) else $error("conversion started while settling");

	property p_bip_mid;
		(div_done && q.div_pend && q.pol_s2 && quo == '0 && q.state == ST_CONV && !cal_rise) |=> q.new_word == CODE_MID;
	endproperty
	a_bip_mid: assert property (p_bip_mid) else $error("bipolar zero did not code to midscale");

	property p_uni_zero;
		(div_done && q.div_pend && !q.pol_s2 && q.div_neg && q.state == ST_CONV && !cal_rise) |=> q.new_word == CODE_ZERO;
	endproperty
	a_uni_zero: assert property (p_uni_zero) else $error("unipolar below zero not clamped");

	property p_rd_result;
		(ahb_take && !hwrite && haddr[ADDR_W-1:0] == REG_RESULT) |=> hrdata == 32'($past(q.result));
	endproperty
	a_rd_result: assert property (p_rd_result) else $error("result read returned wrong data");

	property p_word_wrap;
		word_end |=> (q.word_cnt == '0 && q.acc == '0);
	endproperty
	a_word_wrap: assert property (p_word_wrap) else $error("word period not 1024 master ticks");

endmodule

// file: src/sdc_divider.sv
// Serial restoring divider that applies the stored slope to one measurement.
// Assumes the caller holds start for one cycle and waits for done.
`timescale 1ns/10ps

module sdc_divider
	import sdc_pkg::*;
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Request
	input wire logic start,
	input wire logic [DIV_NW-1:0] dividend,
	input wire logic [DIV_DW-1:0] divisor,
	// Answer
	output logic busy,
	output logic done,
	output logic [DIV_NW-1:0] quotient
);

	sdc_div_regs_t q, d;
	logic [DIV_DW:0] r_sh;
	logic fits;

	// ----------------------------------------------------------------
	// One quotient bit per cycle
	// ----------------------------------------------------------------
	always_comb begin
		d = q;
		d.done = 1'b0;
		r_sh = {q.rem[DIV_DW-1:0], q.num[DIV_NW-1]};
		fits = r_sh >= {1'b0, q.den};
		if (start && !q.busy) begin
			d.busy = 1'b1;
			d.cnt = DIV_CNT_W'(DIV_NW);
			d.rem = '0;
			d.den = divisor;
			d.num = dividend;
			d.quo = '0;
		end else if (q.busy) begin
			d.rem = fits ? r_sh - {1'b0, q.den} : r_sh;
			d.quo = {q.quo[DIV_NW-2:0], fits};
			d.num = {q.num[DIV_NW-2:0], 1'b0};
			d.cnt = q.cnt - DIV_CNT_W'(1);
			if (q.cnt == DIV_CNT_W'(1)) begin
				d.busy = 1'b0;
				d.done = 1'b1;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign busy = q.busy;
	assign done = q.done;
	assign quotient = q.quo;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_div_latency;
		@(posedge hclk) disable iff (!hresetn)
		(start && !q.busy) |-> ##45 done;
	endproperty
	a_div_latency: assert property (p_div_latency) else $error("divider did not finish in 45 cycles");

endmodule

// file: src/sdc_pkg.sv
// Shared constants, types and state records for the sigma-delta calibration control block.
// Assumes one 250 MHz bus clock and a 4.096 MHz master clock arriving as a pin.
package sdc_pkg;

	// ----------------------------------------------------------------
	// Converter timing
	// ----------------------------------------------------------------
	localparam int MCLK_HZ = 4096000;
	localparam int WORD_HZ = 4000;
	localparam int WORD_DIV = MCLK_HZ / WORD_HZ;
	localparam int FILT_DIV = 409600;
	// A first-order step of 2^-k at the word rate puts the corner near fclk/FILT_DIV.
	localparam int FILT_SHIFT = $clog2((FILT_DIV * 100) / (WORD_DIV * 628));
	localparam int SETTLE_MS = 125;
	localparam int SETTLE_WORDS = (SETTLE_MS * WORD_HZ) / 1000;
	localparam int CAL_MIN_HIGH = 4;
	localparam int READY_GAP = 4;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int WORD_BITS = 20;
	localparam int WORD_CNT_W = $clog2(WORD_DIV);
	localparam int ACC_W = WORD_CNT_W + 1;
	localparam int FILT_W = 24;
	localparam int FILT_FRAC = FILT_W - ACC_W;
	localparam int UNI_SHIFT = 20;
	localparam int BI_SHIFT = 19;
	localparam int DIV_NW = FILT_W + UNI_SHIFT;
	localparam int DIV_DW = FILT_W;
	localparam int DIV_CNT_W = 6;
	localparam int PHASE_W = 22;
	localparam int SETTLE_W = 9;
	localparam int HI_CNT_W = 3;
	localparam int GAP_W = 3;
	localparam int ADDR_W = 8;

	// ----------------------------------------------------------------
	// Codes and register map
	// ----------------------------------------------------------------
	localparam logic [WORD_BITS-1:0] CODE_ZERO = 20'h00000;
	localparam logic [WORD_BITS-1:0] CODE_FULL = 20'hFFFFF;
	localparam logic [WORD_BITS-1:0] CODE_MID = 20'h80000;
	localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] REG_RESULT = 8'h08;
	localparam logic [ADDR_W-1:0] REG_ZERO = 8'h0C;
	localparam logic [ADDR_W-1:0] REG_SLOPE = 8'h10;
	localparam int CTRL_FREEZE_BIT = 0;
	localparam int STAT_READY_N_BIT = 0;
	localparam int STAT_BUSY_BIT = 1;
	localparam int STAT_SETTLING_BIT = 2;
	localparam int STAT_OFFSET_BIT = 3;
	localparam int STAT_TWO_STEP_BIT = 4;
	localparam int STAT_BIPOLAR_BIT = 5;
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_CONV = 2'h0,
		ST_ARM = 2'h1,
		ST_CAL_ZERO = 2'h3,
		ST_CAL_FULL = 2'h2
	} sdc_state_t;

	// Encoded as {cal_type_select_1, cal_type_select_2}.
	typedef enum logic [1:0] {
		CAL_SELF = 2'h0,
		CAL_SYS_GAIN = 2'h1,
		CAL_ONE_OFF = 2'h2,
		CAL_SYS_OFF = 2'h3
	} sdc_cal_type_t;

	typedef enum logic [1:0] {
		IN_AIN = 2'h0,
		IN_GND = 2'h1,
		IN_REF = 2'h2
	} sdc_in_sel_t;

	typedef struct packed {
		logic valid;
		logic [WORD_BITS-1:0] word;
	} sdc_result_t;

	typedef struct packed {
		logic busy, done;
		logic [DIV_CNT_W-1:0] cnt;
		logic [DIV_DW:0] rem;
		logic [DIV_DW-1:0] den;
		logic [DIV_NW-1:0] num;
		logic [DIV_NW-1:0] quo;
	} sdc_div_regs_t;

	typedef struct packed {
		logic mclk_s1, mclk_s2, mclk_s3, mod_s1, mod_s2;
		logic cal_s1, cal_s2, cal_s3, sc1_s1, sc1_s2, sc2_s1, sc2_s2, pol_s1, pol_s2, pol_prev;
		sdc_state_t state;
		sdc_cal_type_t cal_type;
		sdc_in_sel_t in_sel;
		logic [HI_CNT_W-1:0] hi_cnt;
		logic [PHASE_W-1:0] phase;
		logic [WORD_CNT_W-1:0] word_cnt;
		logic [ACC_W-1:0] acc;
		logic [FILT_W-1:0] filt, zero, span;
		logic [SETTLE_W-1:0] settle;
		logic [GAP_W-1:0] gap;
		logic ready_n, res_valid, offset_done, two_step_done, freeze, div_start, div_pend, div_neg;
		logic [WORD_BITS-1:0] result, new_word;
		logic aw_valid;
		logic [ADDR_W-1:0] aw_addr;
		logic [31:0] hrdata;
	} sdc_regs_t;

endpackage
